// ### logic/sms_pkg.sv
// package of constants and types for the stop mode sequencer
package sms_pkg;
	// sequencer states
	typedef enum logic [2:0] {
		SMS_RUN = 3'b000,
		SMS_STOP_RET = 3'b001,
		SMS_STOP_DEEP = 3'b010,
		SMS_RECOVER = 3'b011,
		SMS_BG_ACTIVE = 3'b100
	} sms_state_t;
	// regulator encodings
	typedef enum logic [1:0] {
		SMS_REG_FULL = 2'b00,
		SMS_REG_STANDBY = 2'b01,
		SMS_REG_PARTIAL = 2'b10
	} sms_reg_t;
	// debug command classes
	typedef enum logic [1:0] {
		SMS_CMD_NONE = 2'b00,
		SMS_CMD_MEM_STATUS = 2'b01,
		SMS_CMD_BACKGROUND = 2'b10,
		SMS_CMD_OTHER = 2'b11
	} sms_cmd_t;
	localparam int SMS_PIN_W = 8;
	localparam int SMS_IRQ_W = 8;
	localparam logic [7:0] SMS_PIN_RESET = 8'h00;
	// error codes returned to the debug host
	localparam logic [1:0] SMS_ERR_NONE = 2'h0;
	localparam logic [1:0] SMS_ERR_STOPPED = 2'h1;
	localparam logic [1:0] SMS_ERR_NOT_ACTIVE = 2'h2;
	// mclk cycles to hold the recovery reset (bus clock is gated off in recovery)
	localparam int SMS_RECOVER_NS = 1000;
	localparam int SMS_CLK_NS = 100;
	localparam logic [3:0] SMS_RECOVER_CYC = 4'((SMS_RECOVER_NS + SMS_CLK_NS - 1) / SMS_CLK_NS);
endpackage

// ### logic/sms_pin_latch.sv
// pin control latch holding port state through deep stop
`timescale 1ns/1ns
`default_nettype none
module sms_pin_latch (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hold,
	input wire logic [7:0] pin_ctrl_in,
	output logic [7:0] pin_ctrl_out
);
	logic [7:0] cap_reg;
	logic [7:0] cap_next;

	// track the live value until hold rises, then freeze it
	always_comb
	begin
		cap_next = cap_reg;
		if (!hold)
			cap_next = pin_ctrl_in;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			cap_reg <= sms_pkg::SMS_PIN_RESET;
		else
			cap_reg <= cap_next;
	end

	// held value is the one seen at the entry edge, so no live cycle leaks into stop
	assign pin_ctrl_out = hold ? cap_reg : pin_ctrl_in;
endmodule // sms_pin_latch
`default_nettype wire

// ### logic/sms_sequencer.sv
// stop mode sequencer: entry, mode choice, wake and recovery
//
// Behaviour
// [RULE_01] stop with permit enters stop, clocks halted
// [RULE_02] stop without permit forces illegal-opcode reset
// [RULE_03] retained stop standby, deep stop partial powerdown
// [RULE_04] deep/retained chosen by powerdown select
// [RULE_05] debug enabled forces retained stop
// [RULE_06] lowvolt detect in halt keeps regulator active
// [RULE_07] deep stop powers off all but ram, timer
// [RULE_08] deep stop latches all pin controls
// [RULE_09] wake pin low exits deep; output excluded (code excludes only an output driven high)
// [RULE_10] enabled wake timer exits deep stop
// [RULE_11] software sets wake pin as input first
// [RULE_12] deep wake behaves like power-on reset
// [RULE_13] deep wake enables lowvolt reset, holds reset
// [RULE_14] recovered flag and latches held until acknowledge
// [RULE_15] software restores ports before acknowledging
// [RULE_16] unlatched pins follow port control registers
// [RULE_17] retained stop preserves all state
// [RULE_18] retained stop exits on reset or interrupts
// [RULE_19] reset pin resets; interrupt takes its vector
// [RULE_20] debug keeps debug clock, full regulation
// [RULE_21] status memory commands report stopped error
// [RULE_22] background command wakes to active background
// [RULE_23] low-power-run and powerdown select exclusive
// [RULE_24] decision frozen at stop until wake
`timescale 1ns/1ns
`default_nettype none
module sms_sequencer (
	input wire logic mclk,
	input wire logic resetn,
	// cpu side
	input wire logic stop_exec,
	input wire logic halt_entry_permit,
	input wire logic debug_mode_permit,
	input wire logic lowvolt_detect_on,
	input wire logic lowvolt_detect_in_halt,
	// power management register two write port
	input wire logic pmr2_wr,
	input wire logic pmr2_wr_partial_powerdown_select,
	input wire logic pmr2_wr_lpr,
	input wire logic pmr2_wr_ack,
	// wake sources
	input wire logic wake_pin_n,
	input wire logic wake_pin_is_output,
	input wire logic wake_pin_drive_high,
	input wire logic wake_timer_enable,
	input wire logic wake_timer_event,
	input wire logic reset_pin_n,
	input wire logic [7:0] irq_req,
	input wire logic lowvolt_below_trip,
	// debug host
	input wire logic dbg_cmd_valid,
	input wire logic [1:0] dbg_cmd,
	output logic dbg_cmd_accept,
	output logic [1:0] dbg_err,
	// pins
	input wire logic [7:0] pin_ctrl_in,
	output logic [7:0] pin_ctrl_out,
	// status and controls
	output logic partial_powerdown_select,
	output logic low_power_run_request,
	output logic powerdown_recovered_flag,
	output logic bus_clk_en,
	output logic cpu_clk_en,
	output logic debug_clk_en,
	output logic [1:0] regulator_mode,
	output logic core_power_off,
	output logic illegal_op_reset,
	output logic system_reset,
	output logic lowvolt_reset_enable,
	output logic take_irq_vector,
	output logic in_stop
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	sms_pkg::sms_state_t state_reg, state_next;
	logic partial_powerdown_select_reg, partial_powerdown_select_next;
	logic lpr_reg, lpr_next;
	logic powerdown_recovered_flag_reg, powerdown_recovered_flag_next;
	logic reg_act_reg, reg_act_next;
	logic dbg_keep_reg, dbg_keep_next;
	logic ill_reg, ill_next;
	logic rst_reg, rst_next;
	logic vec_reg, vec_next;
	logic lvr_reg, lvr_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [1:0] err_reg, err_next;
	logic acc_reg, acc_next;
	logic wake_pin_ok;
	logic deep_wake;
	logic pin_hold;

	// output driven high does not count as a wake source
	assign wake_pin_ok = !(wake_pin_is_output && wake_pin_drive_high) && !wake_pin_n; // [RULE_09]
	assign deep_wake = wake_pin_ok || (wake_timer_enable && wake_timer_event); // [RULE_09] [RULE_10]

	// ---------------------------------------------------------------
	// sequencer next state
	// ---------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		partial_powerdown_select_next = partial_powerdown_select_reg;
		lpr_next = lpr_reg;
		powerdown_recovered_flag_next = powerdown_recovered_flag_reg;
		reg_act_next = reg_act_reg;
		dbg_keep_next = dbg_keep_reg;
		ill_next = 1'b0;
		rst_next = 1'b0;
		vec_next = 1'b0;
		lvr_next = lvr_reg;
		cnt_next = cnt_reg;
		// mutual exclusion; a write setting both keeps old values
		if (pmr2_wr)
		begin
			if (!(pmr2_wr_partial_powerdown_select && (pmr2_wr_lpr || lpr_reg)))
				partial_powerdown_select_next = pmr2_wr_partial_powerdown_select; // [RULE_23]
			if (!(pmr2_wr_lpr && (pmr2_wr_partial_powerdown_select || partial_powerdown_select_reg)))
				lpr_next = pmr2_wr_lpr; // [RULE_23]
			if (pmr2_wr_ack)
				powerdown_recovered_flag_next = 1'b0; // [RULE_14]
		end
		unique case (state_reg)
			sms_pkg::SMS_RUN:
			begin
				if (stop_exec && !halt_entry_permit)
					ill_next = 1'b1; // [RULE_02]
				else if (stop_exec)
				begin
					// choice frozen from values seen this cycle
					dbg_keep_next = debug_mode_permit; // [RULE_24] [RULE_20]
					reg_act_next = !debug_mode_permit && lowvolt_detect_on && lowvolt_detect_in_halt; // [RULE_06]
					if (partial_powerdown_select_reg && !debug_mode_permit && !(lowvolt_detect_on && lowvolt_detect_in_halt))
						state_next = sms_pkg::SMS_STOP_DEEP; // [RULE_04] [RULE_01]
					else
						state_next = sms_pkg::SMS_STOP_RET; // [RULE_05] [RULE_01]
				end
			end
			sms_pkg::SMS_STOP_RET:
			begin
				// all state simply held in place while clocks stop
				if (!reset_pin_n)
				begin
					rst_next = 1'b1; // [RULE_19]
					state_next = sms_pkg::SMS_RUN; // [RULE_18]
				end
				else if (dbg_keep_reg && dbg_cmd_valid && dbg_cmd == sms_pkg::SMS_CMD_BACKGROUND)
					state_next = sms_pkg::SMS_BG_ACTIVE; // [RULE_22]
				else if (|irq_req)
				begin
					vec_next = 1'b1; // [RULE_19]
					state_next = sms_pkg::SMS_RUN; // [RULE_18] [RULE_17]
				end
			end
			sms_pkg::SMS_STOP_DEEP:
			begin
				if (deep_wake)
				begin
					powerdown_recovered_flag_next = 1'b1; // [RULE_14]
					lvr_next = 1'b1; // [RULE_13]
					cnt_next = sms_pkg::SMS_RECOVER_CYC;
					state_next = sms_pkg::SMS_RECOVER; // [RULE_12]
				end
			end
			sms_pkg::SMS_RECOVER:
			begin
				// reset held until count done and supply above trip
				rst_next = 1'b1; // [RULE_12]
				if (cnt_reg != 4'h0)
					cnt_next = cnt_reg - 4'h1;
				else if (!lowvolt_below_trip)
				begin
					rst_next = 1'b0; // [RULE_13]
					state_next = sms_pkg::SMS_RUN;
				end
			end
			sms_pkg::SMS_BG_ACTIVE:
			begin
				// left by the debug go command, class other
				if (dbg_cmd_valid && dbg_cmd == sms_pkg::SMS_CMD_OTHER && stop_exec)
					state_next = sms_pkg::SMS_RUN;
			end
			default:
				state_next = sms_pkg::SMS_RUN;
		endcase
		if (state_next == sms_pkg::SMS_RUN && state_reg != sms_pkg::SMS_RUN)
		begin
			reg_act_next = 1'b0;
			dbg_keep_next = 1'b0;
		end
	end

	// registers; flag kept over recovery reset, only ack or resetn clears it
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= sms_pkg::SMS_RUN;
			partial_powerdown_select_reg <= 1'b0;
			lpr_reg <= 1'b0;
			powerdown_recovered_flag_reg <= 1'b0;
			reg_act_reg <= 1'b0;
			dbg_keep_reg <= 1'b0;
			ill_reg <= 1'b0;
			rst_reg <= 1'b0;
			vec_reg <= 1'b0;
			lvr_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end
		else
		begin
			state_reg <= state_next;
			partial_powerdown_select_reg <= partial_powerdown_select_next;
			lpr_reg <= lpr_next;
			powerdown_recovered_flag_reg <= powerdown_recovered_flag_next;
			reg_act_reg <= reg_act_next;
			dbg_keep_reg <= dbg_keep_next;
			ill_reg <= ill_next;
			rst_reg <= rst_next;
			vec_reg <= vec_next;
			lvr_reg <= lvr_next;
			cnt_reg <= cnt_next;
		end
	end

	// ---------------------------------------------------------------
	// debug command answer
	// ---------------------------------------------------------------
	always_comb
	begin
		err_next = sms_pkg::SMS_ERR_NONE;
		acc_next = 1'b0;
		if (dbg_cmd_valid)
		begin
			if (state_reg == sms_pkg::SMS_BG_ACTIVE)
				acc_next = 1'b1; // [RULE_22]
			else if (state_reg == sms_pkg::SMS_STOP_RET || state_reg == sms_pkg::SMS_STOP_DEEP)
			begin
				if (dbg_cmd == sms_pkg::SMS_CMD_MEM_STATUS)
					err_next = sms_pkg::SMS_ERR_STOPPED; // [RULE_21]
				else if (dbg_cmd == sms_pkg::SMS_CMD_BACKGROUND && dbg_keep_reg)
					acc_next = 1'b1; // [RULE_22]
				else
					err_next = sms_pkg::SMS_ERR_NOT_ACTIVE;
			end
			else
				acc_next = (dbg_cmd != sms_pkg::SMS_CMD_OTHER);
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			err_reg <= sms_pkg::SMS_ERR_NONE;
			acc_reg <= 1'b0;
		end
		else
		begin
			err_reg <= err_next;
			acc_reg <= acc_next;
		end
	end

	// ---------------------------------------------------------------
	// pin latch and outputs
	// ---------------------------------------------------------------
	// held in deep stop, recovery, and until acknowledge
	assign pin_hold = (state_reg == sms_pkg::SMS_STOP_DEEP) || powerdown_recovered_flag_reg || (state_reg == sms_pkg::SMS_RECOVER); // [RULE_08] [RULE_14]

	// release hands pins back to live port controls
	sms_pin_latch u_latch (
		.mclk(mclk),
		.resetn(resetn),
		.hold(pin_hold),
		.pin_ctrl_in(pin_ctrl_in),
		.pin_ctrl_out(pin_ctrl_out)
	); // [RULE_16]

	assign in_stop = (state_reg == sms_pkg::SMS_STOP_RET) || (state_reg == sms_pkg::SMS_STOP_DEEP);
	assign bus_clk_en = !in_stop && (state_reg != sms_pkg::SMS_RECOVER); // [RULE_01]
	assign cpu_clk_en = bus_clk_en && (state_reg != sms_pkg::SMS_BG_ACTIVE); // [RULE_01]
	assign debug_clk_en = bus_clk_en || (in_stop && dbg_keep_reg); // [RULE_20]
	assign core_power_off = (state_reg == sms_pkg::SMS_STOP_DEEP); // [RULE_07]
	// regulator: partial in deep, standby in retained unless kept on
	assign regulator_mode = (state_reg == sms_pkg::SMS_STOP_DEEP) ? sms_pkg::SMS_REG_PARTIAL
		: (state_reg == sms_pkg::SMS_STOP_RET && !reg_act_reg && !dbg_keep_reg) ? sms_pkg::SMS_REG_STANDBY
		: sms_pkg::SMS_REG_FULL; // [RULE_03] [RULE_06] [RULE_20]
	assign partial_powerdown_select = partial_powerdown_select_reg;
	assign low_power_run_request = lpr_reg;
	assign powerdown_recovered_flag = powerdown_recovered_flag_reg;
	assign illegal_op_reset = ill_reg;
	assign system_reset = rst_reg;
	assign lowvolt_reset_enable = lvr_reg;
	assign take_irq_vector = vec_reg;
	assign dbg_err = err_reg;
	assign dbg_cmd_accept = acc_reg;
endmodule // sms_sequencer
`default_nettype wire

// ### verif/sms_wake_host.sv
// wake pin side model for the stop sequencer bench
`timescale 1ns/1ns
`default_nettype none
module sms_wake_host (
	input wire logic press,
	output logic wake_pin_n,
	output logic wake_pin_is_output,
	output logic wake_pin_drive_high
);
	// ----------
	// pin model
	// ----------
	// a released pin rests at its pull-up level, never the old value
	assign wake_pin_n = press ? 1'h0 : 1'h1;
	// software leaves the pin an input before stop
	assign wake_pin_is_output = 1'h0;
	assign wake_pin_drive_high = 1'h0;
endmodule // sms_wake_host
`default_nettype wire

// ### verif/sms_sequencer_assertions.sv
// port checker for the stop mode sequencer
`timescale 1ns/1ns
`default_nettype none
module sms_sequencer_chk (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic stop_exec,
	input wire logic halt_entry_permit,
	input wire logic debug_mode_permit,
	input wire logic wake_pin_n,
	input wire logic wake_pin_is_output,
	input wire logic wake_pin_drive_high,
	input wire logic reset_pin_n,
	input wire logic [7:0] irq_req,
	input wire logic dbg_cmd_valid,
	input wire logic [1:0] dbg_cmd,
	input wire logic dbg_cmd_accept,
	input wire logic [1:0] dbg_err,
	input wire logic [7:0] pin_ctrl_out,
	input wire logic partial_powerdown_select,
	input wire logic low_power_run_request,
	input wire logic powerdown_recovered_flag,
	input wire logic bus_clk_en,
	input wire logic cpu_clk_en,
	input wire logic debug_clk_en,
	input wire logic [1:0] regulator_mode,
	input wire logic core_power_off,
	input wire logic illegal_op_reset,
	input wire logic system_reset,
	input wire logic lowvolt_reset_enable,
	input wire logic take_irq_vector,
	input wire logic in_stop
);
	// ----------
	// properties
	// ----------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// stop request seen while running normally
	// only the run state has both bus and cpu clocks on
	logic go;
	logic deep;
	assign go = stop_exec && cpu_clk_en;
	assign deep = in_stop && core_power_off;
	chk_stop_entry: assert property (
		go && halt_entry_permit |=> in_stop && !bus_clk_en && !cpu_clk_en) else $error("stop not entered");
	chk_no_permit: assert property (
		go && !halt_entry_permit |=> illegal_op_reset && !in_stop) else $error("no illegal reset");
	chk_deep_reg: assert property (
		deep |-> regulator_mode == sms_pkg::SMS_REG_PARTIAL && !bus_clk_en) else $error("deep regulator");
	chk_dbg_keep: assert property (
		go && halt_entry_permit && debug_mode_permit |=> !core_power_off && debug_clk_en
		&& regulator_mode == sms_pkg::SMS_REG_FULL) else $error("debug stop wrong");
	chk_pin_hold: assert property (
		deep && $past(in_stop) && $past(in_stop, 2) |-> $stable(pin_ctrl_out)) else $error("pins moved");
	chk_pin_wake: assert property (
		deep && !wake_pin_n && !(wake_pin_is_output && wake_pin_drive_high)
		|=> !in_stop && powerdown_recovered_flag && lowvolt_reset_enable) else $error("pin wake");
	chk_irq_wake: assert property (
		in_stop && !core_power_off && reset_pin_n && !dbg_cmd_valid && |irq_req
		|=> !in_stop && take_irq_vector) else $error("irq wake");
	chk_mem_err: assert property (
		in_stop && dbg_cmd_valid && dbg_cmd == sms_pkg::SMS_CMD_MEM_STATUS
		|=> dbg_err == sms_pkg::SMS_ERR_STOPPED && !dbg_cmd_accept) else $error("mem status");
	chk_mode_excl: assert property (
		!(partial_powerdown_select && low_power_run_request)) else $error("lpr and partial_powerdown_select");
	cover property (deep ##1 !in_stop);
	cover property (take_irq_vector);
	cover property (dbg_cmd_accept && !in_stop);
endmodule // sms_sequencer_chk
bind sms_sequencer sms_sequencer_chk u_chk (.*);
`default_nettype wire

// ### verif/tb_sms_sequencer.sv
// self-checking bench for the stop mode sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_sms_sequencer;
	logic mclk, resetn, stop_exec, halt_entry_permit, debug_mode_permit, press;
	logic lowvolt_detect_on, lowvolt_detect_in_halt, pmr2_wr, pmr2_wr_partial_powerdown_select, pmr2_wr_lpr, pmr2_wr_ack;
	logic wake_pin_n, wake_pin_is_output, wake_pin_drive_high, wake_timer_enable, wake_timer_event;
	logic reset_pin_n, lowvolt_below_trip, dbg_cmd_valid, dbg_cmd_accept, bus_clk_en, cpu_clk_en;
	logic partial_powerdown_select, low_power_run_request, powerdown_recovered_flag, in_stop;
	logic debug_clk_en, core_power_off, illegal_op_reset, system_reset, lowvolt_reset_enable, take_irq_vector;
	logic [7:0] irq_req, pin_ctrl_in, pin_ctrl_out;
	logic [1:0] dbg_cmd, dbg_err, regulator_mode;
	int errors = 0;
	int comparisons = 0;
	sms_sequencer u_dut (.*);
	sms_wake_host u_host (.*);
	initial
	begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	// ----------
	// helpers
	// ----------
	// inputs always move 1 ns after the edge so sampling never races
	task automatic tick(input int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// idle cycle after each write so the strobe never re-rises in one step
	task automatic wr(input logic pd, input logic lp, input logic ak);
		{pmr2_wr, pmr2_wr_partial_powerdown_select, pmr2_wr_lpr, pmr2_wr_ack} = {1'h1, pd, lp, ak};
		tick();
		pmr2_wr = 1'h0;
		tick();
	endtask
	task automatic stop();
		stop_exec = 1'h1;
		tick();
		stop_exec = 1'h0;
	endtask
	task automatic cmd(input logic [1:0] c);
		{dbg_cmd_valid, dbg_cmd} = {1'h1, c};
		tick();
		dbg_cmd_valid = 1'h0;
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_excl();
		wr(1'h0, 1'h1, 1'h0);
		wr(1'h1, 1'h1, 1'h0);
		chk({partial_powerdown_select, low_power_run_request}, 9'h001);
		wr(1'h0, 1'h0, 1'h0);
		wr(1'h1, 1'h0, 1'h0);
		wr(1'h1, 1'h1, 1'h0);
		chk({partial_powerdown_select, low_power_run_request}, 9'h002);
	endtask
	task automatic t_deep();
		int i;
		pin_ctrl_in = 8'h5a;
		stop();
		chk({in_stop, core_power_off, bus_clk_en, cpu_clk_en}, 9'h00c);
		chk(regulator_mode, sms_pkg::SMS_REG_PARTIAL);
		pin_ctrl_in = 8'ha5;
		tick(3);
		chk(pin_ctrl_out, 9'h05a);
		press = 1'h1;
		tick();
		press = 1'h0;
		chk({in_stop, powerdown_recovered_flag, lowvolt_reset_enable}, 9'h003);
		tick();
		chk(system_reset, 9'h001);
		for (i = 0; i < 40 && system_reset; i++)
			tick();
		if (system_reset)
		begin
			errors++;
			tally_and_finish();
		end
		chk(9'(i), 9'(sms_pkg::SMS_RECOVER_CYC));
		chk({powerdown_recovered_flag, pin_ctrl_out}, 9'h15a);
		pin_ctrl_in = 8'h3c; // software restores ports first
		wr(1'h1, 1'h0, 1'h1);
		chk({powerdown_recovered_flag, pin_ctrl_out}, 9'h03c);
		// second deep stop: timer wake, recovery held while supply is low
		{wake_timer_enable, lowvolt_below_trip} = 2'h3;
		stop();
		wake_timer_event = 1'h1;
		tick();
		wake_timer_event = 1'h0;
		chk({in_stop, powerdown_recovered_flag}, 9'h001);
		tick(14);
		chk(system_reset, 9'h001);
		lowvolt_below_trip = 1'h0;
		tick(2);
		chk(system_reset, 9'h000);
		wake_timer_enable = 1'h0;
		wr(1'h1, 1'h0, 1'h1);
	endtask
	task automatic t_lowvolt();
		{lowvolt_detect_on, lowvolt_detect_in_halt} = 2'h3;
		stop();
		chk({in_stop, core_power_off, regulator_mode}, {5'h02, sms_pkg::SMS_REG_FULL});
		irq_req = 8'h80;
		tick();
		irq_req = 8'h00;
		chk({in_stop, take_irq_vector}, 9'h001);
		{lowvolt_detect_on, lowvolt_detect_in_halt} = 2'h0;
		// plain retained stop, left through the reset pin
		wr(1'h0, 1'h0, 1'h0);
		stop();
		chk({in_stop, regulator_mode}, {7'h01, sms_pkg::SMS_REG_STANDBY});
		reset_pin_n = 1'h0;
		tick();
		reset_pin_n = 1'h1;
		chk({in_stop, system_reset, take_irq_vector}, 9'h002);
		wr(1'h1, 1'h0, 1'h0);
	endtask
	task automatic t_debug();
		debug_mode_permit = 1'h1;
		stop();
		chk({in_stop, core_power_off, debug_clk_en, regulator_mode}, {4'h5, sms_pkg::SMS_REG_FULL});
		cmd(sms_pkg::SMS_CMD_MEM_STATUS);
		chk({in_stop, dbg_cmd_accept, dbg_err}, {5'h02, sms_pkg::SMS_ERR_STOPPED});
		tick();
		cmd(sms_pkg::SMS_CMD_BACKGROUND);
		chk({in_stop, dbg_cmd_accept}, 9'h001);
		tick();
		cmd(sms_pkg::SMS_CMD_OTHER);
		chk({dbg_cmd_accept, cpu_clk_en}, 9'h002);
		tick();
		// leave active background with the go command
		{stop_exec, dbg_cmd_valid, dbg_cmd} = {2'h3, sms_pkg::SMS_CMD_OTHER};
		tick();
		{stop_exec, dbg_cmd_valid} = 2'h0;
		chk({in_stop, cpu_clk_en, dbg_cmd_accept}, 9'h003);
		debug_mode_permit = 1'h0;
	endtask
	// ----------
	// main sequence
	// ----------
	initial
	begin
		{stop_exec, halt_entry_permit, debug_mode_permit, lowvolt_detect_on, lowvolt_detect_in_halt} = 5'h00;
		{pmr2_wr, pmr2_wr_partial_powerdown_select, pmr2_wr_lpr, pmr2_wr_ack, press} = 5'h00;
		{wake_timer_enable, wake_timer_event, dbg_cmd_valid, lowvolt_below_trip} = 4'h0;
		{reset_pin_n, resetn} = 2'h2;
		{irq_req, pin_ctrl_in, dbg_cmd} = 18'h00000;
		tick(10);
		resetn = 1'h1;
		stop();
		chk({in_stop, illegal_op_reset, bus_clk_en}, 9'h003);
		halt_entry_permit = 1'h1;
		tick(2);
		t_excl();
		t_deep();
		t_lowvolt();
		t_debug();
		tally_and_finish();
	end
endmodule // tb_sms_sequencer
`default_nettype wire
